/* File: inc/ptg_pkg.sv */
package ptg_pkg;

  // ------------------------------------------------------------
  // register offsets on the plain register port
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_PERIOD = 4'h2;
  localparam logic [3:0] REG_WIDTH = 4'h3;
  localparam logic [3:0] REG_DELAY = 4'h4;
  localparam logic [3:0] REG_DWIDTH = 4'h5;
  localparam logic [3:0] REG_DDELAY = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_TSEL = 4'h8;
  localparam logic [3:0] REG_TON = 4'h9;
  localparam logic [3:0] REG_TOFF = 4'hA;
  localparam logic [3:0] REG_TCOUNT = 4'hB;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_MODEN = 0;
  localparam int CTRL_VIDEO = 1;
  localparam int CTRL_PMODE = 2;
  localparam int CTRL_TMODE = 4;
  localparam int CTRL_SLOPE = 6;
  localparam int CTRL_GATEINV = 7;
  localparam int CTRL_SYNCSEL = 8;
  localparam int CMD_MANUAL = 0;
  localparam int STAT_STATE = 0;
  localparam int STAT_PULSE = 2;
  localparam int STAT_VALID = 3;
  localparam int STAT_WERR = 4;
  localparam int STAT_TIDX = 8;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam int RST_PERIOD = 10;
  localparam int RST_WIDTH = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_GAP_NS = 20;
  localparam int MIN_GAP_CYC_RAW =
    (MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_GAP_CYC = (MIN_GAP_CYC_RAW < 1) ? 1 : MIN_GAP_CYC_RAW;
  localparam int SETTLE_CYC = 4;

  // ------------------------------------------------------------
  // modes and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_SINGLE = 2'b00,
    PM_DOUBLE = 2'b01,
    PM_TRAIN = 2'b10
  } ptg_pmode_t;

  typedef enum logic [1:0] {
    TM_AUTO = 2'b00,
    TM_SINGLE = 2'b01,
    TM_GATED = 2'b10
  } ptg_tmode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10
  } ptg_state_t;

endpackage

/* File: hdl/ptg_pulse_train_generator.sv */
`timescale 1ns/1ps
// Behaviour
// [R1] single mode: one pulse in every repetition period
// [R2] double mode: two pulses in every repetition period
// [R3] train mode: high/low times come from stored on/off list
// [R4] period register sets the repetition interval
// [R5] software keeps width at least 20 ns below period
// [R6] external trigger: wait programmed delay before output starts
// [R7] trigger delay ignored in double mode
// [R8] second pulse high time equals second-pulse width
// [R9] second pulse starts programmed interval after first rising edge
// [R10] auto trigger: runs continuously without trigger
// [R11] single-shot: each qualifying edge starts one sequence; edges arriving during delay or run are ignored
// [R12] gated: pulses only while gate is active
// [R13] slope selects rising or falling trigger edges
// [R14] gate polarity: normal active high, inverted active low
// [R15] manual trigger acts like edge, only in single-shot mode
// [R16] each train entry repeats its count before advancing
// [R17] zero-count entries skipped, nonzero count takes part again
// [R18] sync selected: valid output high while settling, else low
// [R19] sync cleared: valid output pulses at each sequence start
// [R20] enabling modulation turns on generator and video output
// [R21] train restarts at first entry after last one
// [R22] counts in clock cycles; reset idles with outputs low
module ptg_pulse_train_generator
  import ptg_pkg::*;
#(
  parameter int CW = 16,
  parameter int N = 8,
  parameter int SETTLE = SETTLE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  // pins
  input wire logic extTriggerGateIn,
  output logic pulseOut,
  output logic videoSyncOut,
  output logic signalValidOut
);

  localparam int IW = (N > 1) ? $clog2(N) : 1;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (CW < 2 || CW > 32) begin : g_cw_chk
    $error("CW must be 2..32");
  end
  if (N < 2 || (1 << IW) != N) begin : g_n_chk
    $error("N must be a power of two, at least 2");
  end
  if (SETTLE < 1 || SETTLE > 255) begin : g_s_chk
    $error("SETTLE must be 1..255");
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [CW-1:0] periodReg, widthReg, delayReg, dWidthReg, dDelayReg;
  logic genOnReg, videoOnReg, slopeReg, gateInvReg, syncSelReg;
  logic [1:0] pmodeReg, tmodeReg;
  logic [CW-1:0] onMem [N];
  logic [CW-1:0] offMem [N];
  logic [CW-1:0] cntMem [N];
  logic [IW-1:0] tSelReg, tIdxReg;
  logic [CW-1:0] tRepReg, phReg;
  logic [CW:0] tPhReg;
  ptg_state_t stateReg;
  logic extPrevReg, pulseReg, videoReg, validReg;
  logic [7:0] settleReg;
  logic [31:0] rdDataReg;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire wrCtrl = wrStb && (addr == REG_CTRL);
  wire wrCmd = wrStb && (addr == REG_CMD);
  wire wrTrain = wrStb && (addr == REG_TON || addr == REG_TOFF ||
                           addr == REG_TCOUNT);
  wire wrTiming = wrStb && (addr >= REG_PERIOD && addr <= REG_DDELAY);
  wire [CW-1:0] wrVal = wrData[CW-1:0];
  // a fresh enable switches the video output on as well
  wire modEnRise = wrCtrl && wrData[CTRL_MODEN] && !genOnReg;

  // ------------------------------------------------------------
  // trigger and gate qualification
  // ------------------------------------------------------------
  wire isAuto = (tmodeReg == TM_AUTO);
  wire isSingle = (tmodeReg == TM_SINGLE);
  wire isGated = (tmodeReg == TM_GATED);
  wire isDouble = (pmodeReg == PM_DOUBLE);
  wire isTrain = (pmodeReg == PM_TRAIN);
  // [R13] edge select
  wire trigEdge = slopeReg ? (extPrevReg && !extTriggerGateIn)
                           : (!extPrevReg && extTriggerGateIn);
  // [R14] gate polarity
  wire gateActive = extTriggerGateIn ^ gateInvReg;
  // [R15] manual only in single-shot
  wire manualTrig = wrCmd && wrData[CMD_MANUAL] && isSingle;
  // [R11] edge or manual starts sequence
  wire trigAccept = genOnReg && isSingle && (trigEdge || manualTrig);

  // ------------------------------------------------------------
  // train list search for next nonzero entry
  // ------------------------------------------------------------
  function automatic logic [IW:0] findNz(input logic [IW-1:0] start);
    logic [IW:0] res;
    logic [IW-1:0] j;
    res = '0;
    j = start;
    for (int i = N - 1; i >= 0; i--) begin
      j = start + IW'(i);
      if (cntMem[j] != '0) begin
        res = {1'b1, j};
      end
    end
    return res;
  endfunction

  // [R17] zero counts skipped
  wire [IW:0] firstNz = findNz('0);
  wire [IW:0] nextNz = findNz(tIdxReg + 1'b1);
  wire anyEntry = firstNz[IW];
  wire [IW-1:0] nextIdx = nextNz[IW-1:0];
  wire wrapped = (nextIdx <= tIdxReg);

  // ------------------------------------------------------------
  // sequence timing terms
  // ------------------------------------------------------------
  wire [CW-1:0] perLen = (periodReg == '0) ? CW'(1) : periodReg;
  // [R4] period bounds phase counter
  wire periodEnd = (phReg == perLen - 1'b1);
  wire [CW:0] trainLen = {1'b0, onMem[tIdxReg]} + {1'b0, offMem[tIdxReg]};
  wire tStepEnd = (trainLen == '0) || (tPhReg == trainLen - 1'b1);
  wire repEnd = (tRepReg + 1'b1 >= cntMem[tIdxReg]);
  wire seqEnd = isTrain ? (tStepEnd && repEnd && wrapped) : periodEnd;
  wire canRun = genOnReg && (!isTrain || anyEntry);
  wire freeRun = isAuto || (isGated && gateActive);
  wire delayOn = (delayReg != '0) && !isDouble;
  wire [CW:0] dEnd = {1'b0, dDelayReg} + {1'b0, dWidthReg};
  wire widthErr = ({1'b0, widthReg} + (CW+1)'(MIN_GAP_CYC)) >
                  {1'b0, perLen};

  // [R1] first pulse in each period
  wire firstHigh = (phReg < widthReg);
  // [R8] [R9] second pulse window
  wire secondHigh = ({1'b0, phReg} >= {1'b0, dDelayReg}) &&
                    ({1'b0, phReg} < dEnd);
  // [R3] train on time
  wire trainHigh = (tPhReg < {1'b0, onMem[tIdxReg]});
  // [R2] double adds second
  wire levelNow = isTrain ? trainHigh :
                  (isDouble ? (firstHigh || secondHigh) : firstHigh);
  // [R12] gate cuts output at once
  wire pulseNext = (stateReg == ST_RUN) && levelNow &&
                   !(isGated && !gateActive);
  wire seqStart = (stateReg == ST_RUN) &&
                  (isTrain ? (tIdxReg == firstNz[IW-1:0] &&
                              tRepReg == '0 && tPhReg == '0)
                           : (phReg == '0));

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      genOnReg <= 1'b0;
      videoOnReg <= 1'b0;
      pmodeReg <= PM_SINGLE;
      tmodeReg <= TM_AUTO;
      slopeReg <= 1'b0;
      gateInvReg <= 1'b0;
      syncSelReg <= 1'b0;
    end else if (wrCtrl) begin
      genOnReg <= wrData[CTRL_MODEN];
      // [R20] fresh enable forces video on
      videoOnReg <= wrData[CTRL_VIDEO] || modEnRise;
      pmodeReg <= wrData[CTRL_PMODE +: 2];
      tmodeReg <= wrData[CTRL_TMODE +: 2];
      slopeReg <= wrData[CTRL_SLOPE];
      gateInvReg <= wrData[CTRL_GATEINV];
      syncSelReg <= wrData[CTRL_SYNCSEL];
    end
  end

  // timing registers
  always_ff @(posedge clock) begin
    if (rst) begin
      periodReg <= CW'(RST_PERIOD);
      widthReg <= CW'(RST_WIDTH);
      delayReg <= '0;
      dWidthReg <= '0;
      dDelayReg <= '0;
      tSelReg <= '0;
    end else if (wrStb) begin
      if (addr == REG_PERIOD) periodReg <= wrVal;
      if (addr == REG_WIDTH) widthReg <= wrVal;
      if (addr == REG_DELAY) delayReg <= wrVal;
      if (addr == REG_DWIDTH) dWidthReg <= wrVal;
      if (addr == REG_DDELAY) dDelayReg <= wrVal;
      if (addr == REG_TSEL) tSelReg <= wrData[IW-1:0];
    end
  end

  // train list entries, empty after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        onMem[i] <= '0;
        offMem[i] <= '0;
        cntMem[i] <= '0;
      end
    end else if (wrTrain) begin
      if (addr == REG_TON) onMem[tSelReg] <= wrVal;
      if (addr == REG_TOFF) offMem[tSelReg] <= wrVal;
      if (addr == REG_TCOUNT) cntMem[tSelReg] <= wrVal;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      // [R22] idle after reset
      stateReg <= ST_IDLE;
      phReg <= '0;
      tIdxReg <= '0;
      tRepReg <= '0;
      tPhReg <= '0;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          phReg <= '0;
          tRepReg <= '0;
          tPhReg <= '0;
          tIdxReg <= firstNz[IW-1:0];
          // [R10] auto start
          if (canRun && freeRun) begin
            stateReg <= ST_RUN;
          end else if (canRun && trigAccept) begin
            // [R6] [R7] delay unless double
            stateReg <= delayOn ? ST_DELAY : ST_RUN;
          end
        end
        ST_DELAY: begin
          if (!genOnReg) begin
            stateReg <= ST_IDLE;
          end else if (phReg == delayReg - 1'b1) begin
            stateReg <= ST_RUN;
            phReg <= '0;
          end else begin
            phReg <= phReg + 1'b1;
          end
        end
        ST_RUN: begin
          phReg <= periodEnd ? '0 : phReg + 1'b1;
          tPhReg <= tStepEnd ? '0 : tPhReg + 1'b1;
          // [R16] repeat, then advance
          if (tStepEnd) begin
            tRepReg <= repEnd ? '0 : tRepReg + 1'b1;
            // [R21] wraps to first entry
            if (repEnd) tIdxReg <= nextIdx;
          end
          if (!canRun || (isGated && !gateActive) ||
              (isSingle && seqEnd)) begin
            stateReg <= ST_IDLE;
          end
        end
        default: stateReg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs and settle timer
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      extPrevReg <= 1'b0;
      pulseReg <= 1'b0;
      videoReg <= 1'b0;
      validReg <= 1'b0;
      settleReg <= '0;
    end else begin
      extPrevReg <= extTriggerGateIn;
      pulseReg <= pulseNext;
      videoReg <= pulseNext && videoOnReg;
      if (wrCtrl || wrTiming || wrTrain) begin
        settleReg <= 8'(SETTLE);
      end else if (settleReg != '0) begin
        settleReg <= settleReg - 1'b1;
      end
      // [R18] [R19] settle level or start pulse
      validReg <= syncSelReg ? (settleReg != '0) : seqStart;
    end
  end

  // read mux, data only in the cycle after the strobe
  wire [31:0] ctrlRd = 32'({syncSelReg, gateInvReg, slopeReg, tmodeReg,
                            pmodeReg, videoOnReg, genOnReg});
  wire [31:0] statRd = 32'({tIdxReg, 3'b000, widthErr, validReg,
                            pulseReg, stateReg});
  wire [31:0] rdMux =
    (addr == REG_CTRL) ? ctrlRd :
    (addr == REG_PERIOD) ? 32'(periodReg) :
    (addr == REG_WIDTH) ? 32'(widthReg) :
    (addr == REG_DELAY) ? 32'(delayReg) :
    (addr == REG_DWIDTH) ? 32'(dWidthReg) :
    (addr == REG_DDELAY) ? 32'(dDelayReg) :
    (addr == REG_STATUS) ? statRd :
    (addr == REG_TSEL) ? 32'(tSelReg) :
    (addr == REG_TON) ? 32'(onMem[tSelReg]) :
    (addr == REG_TOFF) ? 32'(offMem[tSelReg]) :
    (addr == REG_TCOUNT) ? 32'(cntMem[tSelReg]) : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (rst) rdDataReg <= 32'h0000_0000;
    else rdDataReg <= rdStb ? rdMux : 32'h0000_0000;
  end

  assign rdData = rdDataReg;
  assign pulseOut = pulseReg;
  assign videoSyncOut = videoReg;
  assign signalValidOut = validReg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_idle_low;
    @(posedge clock) disable iff (rst)
    stateReg == ST_IDLE |=> !pulseOut;
  endproperty
  a_idle_low: assert property (p_idle_low) // [R22]
    else $error("pulse high while idle");

  property p_first_rise;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_RUN && !isTrain && phReg == '0 && widthReg != '0 &&
     !isGated) |=> pulseOut;
  endproperty
  a_first_rise: assert property (p_first_rise) // [R1]
    else $error("no pulse at period start");

  property p_period_wrap;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_RUN && periodEnd && $stable(periodReg)) |=>
      (phReg == '0);
  endproperty
  a_period_wrap: assert property (p_period_wrap) // [R4]
    else $error("phase did not wrap at period end");

  property p_second_start;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_RUN && isDouble && !isGated && phReg == dDelayReg &&
     dWidthReg != '0) |=> pulseOut;
  endproperty
  a_second_start: assert property (p_second_start) // [R9]
    else $error("second pulse missing");

  property p_second_end;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_RUN && isDouble && {1'b0, phReg} == dEnd &&
     phReg >= widthReg) |=> !pulseOut;
  endproperty
  a_second_end: assert property (p_second_end) // [R8]
    else $error("second pulse too long");

  property p_delay_wait;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_IDLE && canRun && !freeRun && trigAccept &&
     delayOn && delayReg == CW'(3)) |=>
      stateReg == ST_DELAY ##1 stateReg == ST_DELAY ##1
      stateReg == ST_DELAY ##1 stateReg != ST_DELAY;
  endproperty
  a_delay_wait: assert property (p_delay_wait) // [R6]
    else $error("trigger delay wrong");

  property p_double_nodelay;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_IDLE && canRun && !freeRun && trigAccept &&
     isDouble) |=> stateReg == ST_RUN;
  endproperty
  a_double_nodelay: assert property (p_double_nodelay) // [R7]
    else $error("delay applied in double mode");

  property p_auto_run;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_IDLE && canRun && isAuto) |=> stateReg == ST_RUN;
  endproperty
  a_auto_run: assert property (p_auto_run) // [R10]
    else $error("auto mode did not start");

  property p_gate_off;
    @(posedge clock) disable iff (rst)
    (isGated && !gateActive) |=> !pulseOut;
  endproperty
  a_gate_off: assert property (p_gate_off) // [R12]
    else $error("pulse while gate inactive");

  property p_skip_zero;
    @(posedge clock) disable iff (rst)
    (stateReg == ST_RUN && isTrain && $stable(tIdxReg)) |->
      cntMem[tIdxReg] != '0;
  endproperty
  a_skip_zero: assert property (p_skip_zero) // [R17]
    else $error("zero-count entry played");

  property p_sync_single;
    @(posedge clock) disable iff (rst)
    (!syncSelReg && signalValidOut && perLen > CW'(1) && !isTrain &&
     $stable(syncSelReg)) |=> !signalValidOut;
  endproperty
  a_sync_single: assert property (p_sync_single) // [R19]
    else $error("sync pulse longer than one cycle");

  property p_video_on;
    @(posedge clock) disable iff (rst)
    modEnRise |=> (genOnReg && videoOnReg);
  endproperty
  a_video_on: assert property (p_video_on) // [R20]
    else $error("enable did not switch video on");

endmodule // ptg_pulse_train_generator

/* File: tb/ptg_trig_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// external trigger or gate source
// ----------------------------------------
module ptg_trig_src (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // level asked for by the bench
  input wire logic wantLevel,
  // pin towards the generator
  output logic pin
);
  // pin follows request one clock later, idle low in reset
  always_ff @(posedge clock) begin
    if (rst) begin
      pin <= 1'b0;
    end else begin
      pin <= wantLevel;
    end
  end
endmodule // ptg_trig_src

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// pulse train generator bench
// ----------------------------------------
module tb_top import ptg_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [31:0] rdData;
  logic wantLevel = 1'b0;
  logic extPin, pulseOut, videoSyncOut, signalValidOut;
  logic [31:0] v;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int hi, rises, vid, vHigh, vPul;
  int runs[$];
  int riseAt[$];
  int expA[6] = '{2, 2, 1, 2, 2, 1};
  int expB[6] = '{2, 2, 5, 1, 2, 2};

  ptg_pulse_train_generator uut (.clock(clock), .rst(rst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .extTriggerGateIn(extPin), .pulseOut(pulseOut),
    .videoSyncOut(videoSyncOut), .signalValidOut(signalValidOut));

  ptg_trig_src src (.clock(clock), .rst(rst), .wantLevel(wantLevel),
    .pin(extPin));

  // 10 MHz clock
  initial begin
    forever #50 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic pin(input logic lv);
    @(posedge clock);
    wantLevel <= lv;
  endtask

  task automatic ent(input int i, on, off, cnt);
    wr(REG_TSEL, 32'(i));
    wr(REG_TON, 32'(on));
    wr(REG_TOFF, 32'(off));
    wr(REG_TCOUNT, 32'(cnt));
  endtask

  function automatic logic [31:0] ctl(input logic en, vd,
    input logic [1:0] pm, tm, input logic sl, inv, sy);
    ctl = 32'h0;
    ctl[CTRL_MODEN] = en;
    ctl[CTRL_VIDEO] = vd;
    ctl[CTRL_PMODE +: 2] = pm;
    ctl[CTRL_TMODE +: 2] = tm;
    ctl[CTRL_SLOPE] = sl;
    ctl[CTRL_GATEINV] = inv;
    ctl[CTRL_SYNCSEL] = sy;
  endfunction

  // sample outputs for n cycles, gather high runs and rise times
  task automatic watch(input int n);
    int run;
    logic pp, pv;
    run = 0;
    hi = 0;
    rises = 0;
    vid = 0;
    vHigh = 0;
    vPul = 0;
    runs.delete();
    riseAt.delete();
    pp = pulseOut;
    pv = signalValidOut;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      if (pulseOut === 1'b1) begin
        hi++;
        run++;
        if (pp !== 1'b1) begin
          rises++;
          riseAt.push_back(i);
        end
      end else if (run > 0) begin
        runs.push_back(run);
        run = 0;
      end
      if (videoSyncOut === 1'b1) vid++;
      if (signalValidOut === 1'b1) vHigh++;
      if (signalValidOut === 1'b1 && pv !== 1'b1) vPul++;
      pp = pulseOut;
      pv = signalValidOut;
    end
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(REG_PERIOD, v); check(v, 32'hA);
    rd(REG_WIDTH, v); check(v, 32'h4);
    rd(4'hF, v); check(v, 32'h0);
    check(pulseOut, 1'b0);
    wr(REG_PERIOD, 32'h6);
    wr(REG_WIDTH, 32'h2);
    wr(REG_CTRL, ctl(1, 0, PM_SINGLE, TM_AUTO, 0, 0, 0));
    repeat (10) @(posedge clock);
    watch(60);
    check(rises, 10);
    check(hi, 20);
    check(vid, 20);
    wr(REG_CTRL, ctl(1, 0, PM_SINGLE, TM_AUTO, 0, 0, 0));
    watch(30);
    check(vid, 0);
    // single-shot, rising edge, delay 3
    wr(REG_CTRL, 32'h0);
    wr(REG_DELAY, 32'h3);
    wr(REG_CTRL, ctl(1, 1, PM_SINGLE, TM_SINGLE, 0, 0, 0));
    pin(1'b1);
    watch(40);
    check(rises, 1);
    // pin lag and edge sample take 2 cycles, then delay 3
    check(riseAt[0], 5);
    check(vPul, 1);
    wr(REG_CTRL, ctl(1, 1, PM_SINGLE, TM_SINGLE, 1, 0, 0));
    pin(1'b0);
    watch(30);
    check(rises, 1);
    pin(1'b1);
    watch(30);
    check(rises, 0);
    wr(REG_CMD, 32'h1);
    watch(30);
    check(rises, 1);
    // double pulse, delay ignored
    wr(REG_CTRL, 32'h0);
    wr(REG_PERIOD, 32'd20);
    wr(REG_WIDTH, 32'h3);
    wr(REG_DELAY, 32'h5);
    wr(REG_DWIDTH, 32'h2);
    wr(REG_DDELAY, 32'h8);
    wr(REG_CTRL, ctl(1, 1, PM_DOUBLE, TM_SINGLE, 0, 0, 0));
    pin(1'b0);
    repeat (3) @(posedge clock);
    pin(1'b1);
    watch(40);
    check(rises, 2);
    check(riseAt[0], 2);
    check(riseAt[1] - riseAt[0], 8);
    check(runs[1], 2);
    // gated, normal then inverse; gate low before enabling
    wr(REG_CTRL, 32'h0);
    pin(1'b0);
    wr(REG_PERIOD, 32'h6);
    wr(REG_WIDTH, 32'h2);
    wr(REG_CTRL, ctl(1, 1, PM_SINGLE, TM_GATED, 0, 0, 0));
    watch(20);
    check(rises, 0);
    pin(1'b1);
    watch(30);
    check(rises, 5);
    wr(REG_CTRL, ctl(1, 1, PM_SINGLE, TM_GATED, 0, 1, 0));
    wr(REG_CMD, 32'h1);
    watch(20);
    check(rises, 0);
    pin(1'b0);
    watch(30);
    check(rises, 5);
    // train list, middle entry skipped then enabled
    wr(REG_CTRL, 32'h0);
    ent(0, 2, 3, 2);
    ent(1, 5, 5, 0);
    ent(2, 1, 1, 1);
    wr(REG_CTRL, ctl(1, 1, PM_TRAIN, TM_AUTO, 0, 0, 0));
    watch(40);
    foreach (expA[i]) check(runs[i], expA[i]);
    wr(REG_CTRL, 32'h0);
    ent(1, 5, 5, 1);
    wr(REG_CTRL, ctl(1, 1, PM_TRAIN, TM_AUTO, 0, 0, 0));
    watch(40);
    foreach (expB[i]) check(runs[i], expB[i]);
    // settle indication
    wr(REG_CTRL, ctl(1, 1, PM_SINGLE, TM_AUTO, 0, 0, 1));
    watch(10);
    wr(REG_PERIOD, 32'h6);
    watch(12);
    check(vHigh, 4);
    // reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check({pulseOut, videoSyncOut, signalValidOut}, 3'b000);
    @(posedge clock);
    rst <= 1'b0;
    rd(REG_PERIOD, v); check(v, 32'hA);
    rd(REG_CTRL, v); check(v, 32'h0);
    give_verdict();
  end
endmodule // tb_top
